// [src/rsr_repacker.sv]
/*
 * Refresh symbol repacker engine and its symbol FIFO. The engine copies the old
 * descriptor table of one sort bin into a new one, then streams old refresh
 * symbols and new sort-bin symbols through the FIFO into new refresh storage.
 * Assumes a single-outstanding doubleword storage port answering with ack/err,
 * big-endian byte order (byte 0 in bits 63:56) and operands loaded by the caller.
 */
`timescale 1ns/1ns

module rsr_fifo #(
	parameter int unsigned WIDTH = 64,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_FILL = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      fill_reg;
	logic             push;
	logic             pop;

	// honest full and empty from the fill level
	assign in_ready  = (fill_reg != FULL_FILL);
	assign out_valid = (fill_reg != '0);
	assign out_data  = store[rd_ptr_reg];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// pointers and fill level
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			fill_reg   <= '0;
		end else begin
			if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop) fill_reg <= fill_reg + 1'b1;
			else if (pop && !push) fill_reg <= fill_reg - 1'b1;
		end
	end

	// storage array, no reset needed
	always_ff @(posedge clk_sys) begin
		if (push) store[wr_ptr_reg] <= in_data;
	end
endmodule : rsr_fifo

module rsr_repacker
	import rsr_pkg::*;
(
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	input  wire logic         start,
	input  wire rsr_regs_s    regs_in,
	input  wire logic [23:0]  sort_bin_base_address_in,
	input  wire logic [3:0]   bin_sel,
	input  wire logic [23:0]  wct_addr,
	input  wire logic [3:0]   class_count,
	input  wire logic         class_radar,
	input  wire logic [15:0]  new_sym_count,
	input  wire logic [7:0]   reentry_in,
	input  wire logic         irq_pending,
	input  wire rsr_mem_rsp_s mem_rsp,
	output rsr_mem_req_s      mem_req,
	output rsr_regs_s         regs_out,
	output logic [7:0]        reentry_out,
	output rsr_end_e          end_code,
	output logic              busy,
	output logic              done
);
	rsr_ctx_s    ctx_reg;
	rsr_ctx_s    ctx_next;
	logic        ack;
	logic        ack_ok;
	logic [1:0]  half_idx;
	logic [15:0] cur_desc;
	logic        sep;
	logic [15:0] desc_bytes;
	logic [23:0] disp_addr;
	logic [23:0] disp_start;
	logic [31:0] disp_word;
	rsr_regs_s   mv_src;
	logic [16:0] mv_bytes;
	logic [15:0] mv_dw;
	logic [16:0] ins_sym;
	logic [15:0] ins_dw;
	logic        mv_idle;
	logic        rd_go;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [63:0] fifo_out_data;
	logic        fifo_push;
	logic        fifo_pop;

	// halfword k of a doubleword, descriptor batch byte then count byte
	function automatic logic [15:0] rsr_half(input logic [63:0] dw, input logic [1:0] idx);
		rsr_half = dw[63 - 16*idx -: 16];
	endfunction : rsr_half

	// switch to refresh image moving with a doubleword count
	function automatic rsr_ctx_s rsr_enter_move(input rsr_ctx_s c, input logic [15:0] dws);
		rsr_ctx_s r;
		r           = c;
		r.st        = RSR_S_MOVE;
		r.insert_ph = 1'b0;
		r.pre       = (dws == 16'h0000);
		r.rd_left   = (dws == 16'h0000) ? 16'h0001 : dws;
		r.wr_left   = dws;
		rsr_enter_move = r;
	endfunction : rsr_enter_move

	// outputs straight from the context flops
	assign mem_req     = ctx_reg.req;
	assign regs_out    = ctx_reg.regs;
	assign reentry_out = ctx_reg.reent;
	assign end_code    = ctx_reg.endc;
	assign busy        = ctx_reg.busy;
	assign done        = ctx_reg.done;

	// storage answer and descriptor decode
	assign ack        = mem_rsp.ack & ctx_reg.req.valid;
	assign ack_ok     = ack & ~mem_rsp.err;
	assign half_idx   = ctx_reg.regs.old_table_pointer[2:1];
	assign cur_desc   = rsr_half(ctx_reg.dw, half_idx);
	assign sep        = (cur_desc[15:8] == 8'h00);
	assign desc_bytes = {6'h00, cur_desc[7:0], 2'h0};               // four bytes per symbol
	assign disp_addr  = ctx_reg.work_control_table + {18'h00000, ctx_reg.bin, 2'h0};
	assign disp_start = wct_addr + {18'h00000, bin_sel, 2'h0};
	assign disp_word  = disp_addr[2] ? mem_rsp.rdata[31:0] : mem_rsp.rdata[63:32];

	// transfer sizes of the two moving phases
	assign mv_src   = (ctx_reg.st == RSR_S_IDLE) ? regs_in : ctx_reg.regs; // resume uses operands
	assign mv_bytes = {1'h0, mv_src.history_symbol_count[15:0]}
		+ {1'h0, mv_src.current_symbol_count[15:0]} + RSR_DW_ROUND;
	assign mv_dw    = {2'h0, mv_bytes[16:3]};
	assign ins_sym  = {1'h0, ctx_reg.nsym} + RSR_SYM_ROUND;
	assign ins_dw   = ins_sym[16:1];

	// mover: reads first until the FIFO fills, then drains to new refresh
	assign mv_idle   = (ctx_reg.st == RSR_S_MOVE) & ~ctx_reg.req.valid;
	assign rd_go     = mv_idle & (ctx_reg.rd_left != 16'h0000) & (fifo_in_ready | ctx_reg.pre);
	assign fifo_pop  = mv_idle & ~rd_go & (ctx_reg.wr_left != 16'h0000) & fifo_out_valid;
	assign fifo_push = (ctx_reg.st == RSR_S_MOVE) & ack_ok & ~ctx_reg.req.write & ~ctx_reg.pre;

	rsr_fifo #(
		.WIDTH (RSR_DW_W),
		.DEPTH (RSR_FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.in_data   (mem_rsp.rdata),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	// next context of the engine
	always_comb begin
		ctx_next = ctx_reg;
		ctx_next.done = 1'b0;
		if (ack) ctx_next.req.valid = 1'b0;
		if (ack && mem_rsp.err && ctx_reg.busy) begin
			ctx_next.st   = RSR_S_DONE;
			ctx_next.endc = RSR_END_ADDR;
		end else begin
			case (ctx_reg.st)
				RSR_S_IDLE: begin
					if (start) begin
						ctx_next.regs   = regs_in;
						ctx_next.sort_bin_base_address   = sort_bin_base_address_in;
						ctx_next.work_control_table    = wct_addr;
						ctx_next.bin    = bin_sel;
						ctx_next.nsym   = new_sym_count;
						ctx_next.radar  = class_radar;
						ctx_next.classes_left = class_count;
						ctx_next.in_current   = 1'b0;
						ctx_next.held   = 1'b0;
						ctx_next.tdone  = 1'b0;
						ctx_next.busy   = 1'b1;
						ctx_next.endc   = RSR_END_OK;
						ctx_next.reent  = reentry_in;
						if (regs_in.old_refresh_pointer[2:0] != RSR_DW_OFS0 ||
							regs_in.new_refresh_pointer[2:0] != RSR_DW_OFS0) begin
							ctx_next.st   = RSR_S_DONE;
							ctx_next.endc = RSR_END_SPEC;
						end else if (reentry_in[7:4] == RSR_REENTRY_IMAGE) begin
							ctx_next = rsr_enter_move(ctx_next, mv_dw);
						end else begin
							if (reentry_in == RSR_REENTRY_NONE) begin
								ctx_next.regs.history_symbol_count[15:0] = 16'h0000;
								ctx_next.regs.current_symbol_count[15:0] = 16'h0000;
							end
							ctx_next.st        = RSR_S_DISP;
							ctx_next.req.valid = 1'b1;
							ctx_next.req.write = 1'b0;
							ctx_next.req.addr  = {disp_start[23:3], RSR_DW_OFS0};
						end
					end
				end
				RSR_S_DISP: begin
					if (ack_ok) begin
						ctx_next.regs.sort_bin_fetch_pointer[23:0] =
							ctx_reg.sort_bin_base_address + disp_word[23:0];
						ctx_next.st        = RSR_S_TRD;
						ctx_next.req.valid = 1'b1;
						ctx_next.req.write = 1'b0;
						ctx_next.req.addr  = {ctx_reg.regs.old_table_pointer[23:3], RSR_DW_OFS0};
					end
				end
				RSR_S_TRD: begin
					if (ack_ok) begin
						ctx_next.dw   = mem_rsp.rdata;
						ctx_next.held = 1'b1;
						ctx_next.st   = RSR_S_TPROC;
					end
				end
				RSR_S_TPROC: begin
					ctx_next.regs.old_table_pointer[23:0] =
						ctx_reg.regs.old_table_pointer[23:0] + RSR_DESC_STEP;
					if (half_idx == RSR_LAST_HALF) ctx_next.held = 1'b0;
					ctx_next.st        = RSR_S_TWR;
					ctx_next.req.valid = 1'b1;
					ctx_next.req.write = 1'b1;
					ctx_next.req.addr  = {ctx_reg.regs.new_table_pointer[23:3], RSR_DW_OFS0};
					ctx_next.req.be    = RSR_HALF_BE >> {ctx_reg.regs.new_table_pointer[2:1], 1'h0};
					ctx_next.req.wdata = sep ? 64'h0 : {4{cur_desc}};
					if (sep) begin
						if (ctx_reg.radar && !ctx_reg.in_current) begin
							ctx_next.in_current = 1'b1;
						end else begin
							ctx_next.in_current   = 1'b0;
							ctx_next.classes_left = ctx_reg.classes_left - 4'h1;
							if (ctx_reg.classes_left == 4'h1) ctx_next.tdone = 1'b1;
						end
					end else if (ctx_reg.radar && !ctx_reg.in_current) begin
						ctx_next.regs.history_symbol_count[15:0] =
							ctx_reg.regs.history_symbol_count[15:0] + desc_bytes;
					end else begin
						ctx_next.regs.current_symbol_count[15:0] =
							ctx_reg.regs.current_symbol_count[15:0] + desc_bytes;
					end
				end
				RSR_S_TWR: begin
					if (ack_ok) begin
						ctx_next.regs.new_table_pointer[23:0] =
							ctx_reg.regs.new_table_pointer[23:0] + RSR_DESC_STEP;
						if (ctx_reg.tdone) begin
							ctx_next.tdone = 1'b0;
							if (irq_pending) begin
								ctx_next.st    = RSR_S_DONE;
								ctx_next.endc  = RSR_END_INTR;
								ctx_next.reent = RSR_EXIT_TABLE;
							end else begin
								ctx_next = rsr_enter_move(ctx_next, mv_dw);
							end
						end else if (ctx_reg.held) begin
							ctx_next.st = RSR_S_TPROC;
						end else begin
							ctx_next.st        = RSR_S_TRD;
							ctx_next.req.valid = 1'b1;
							ctx_next.req.write = 1'b0;
							ctx_next.req.addr  =
								{ctx_next.regs.old_table_pointer[23:3], RSR_DW_OFS0};
						end
					end
				end
				RSR_S_MOVE: begin
					if (ack_ok && !ctx_reg.req.write) begin
						if (ctx_reg.pre) begin
							ctx_next.pre     = 1'b0;
							ctx_next.rd_left = 16'h0000;
						end else begin
							ctx_next.rd_left = ctx_reg.rd_left - 16'h0001;
							if (ctx_reg.insert_ph) begin
								ctx_next.regs.sort_bin_fetch_pointer[23:0] =
									ctx_reg.regs.sort_bin_fetch_pointer[23:0]
									+ RSR_DW_STEP;
							end else begin
								ctx_next.regs.old_refresh_pointer[23:0] =
									ctx_reg.regs.old_refresh_pointer[23:0] + RSR_DW_STEP;
							end
						end
					end else if (ack_ok) begin
						ctx_next.regs.new_refresh_pointer[23:0] =
							ctx_reg.regs.new_refresh_pointer[23:0] + RSR_DW_STEP;
					end else if (rd_go) begin
						ctx_next.req.valid = 1'b1;
						ctx_next.req.write = 1'b0;
						ctx_next.req.addr  = ctx_reg.insert_ph ?
							{ctx_reg.regs.sort_bin_fetch_pointer[23:3], RSR_DW_OFS0} :
							ctx_reg.regs.old_refresh_pointer[23:0];
					end else if (fifo_pop) begin
						ctx_next.req.valid = 1'b1;
						ctx_next.req.write = 1'b1;
						ctx_next.req.be    = 8'hFF;
						ctx_next.req.addr  = ctx_reg.regs.new_refresh_pointer[23:0];
						ctx_next.req.wdata = fifo_out_data;
						ctx_next.wr_left   = ctx_reg.wr_left - 16'h0001;
					end else if (mv_idle && ctx_reg.rd_left == 16'h0000 &&
						ctx_reg.wr_left == 16'h0000) begin
						if (!ctx_reg.insert_ph) begin
							ctx_next.insert_ph = 1'b1;
							ctx_next.rd_left   = ins_dw;
							ctx_next.wr_left   = ins_dw;
						end else begin
							ctx_next.st    = RSR_S_DONE;
							ctx_next.reent = RSR_REENTRY_NONE;
						end
					end
				end
				RSR_S_DONE: begin
					ctx_next.done = 1'b1;
					ctx_next.busy = 1'b0;
					ctx_next.st   = RSR_S_IDLE;
				end
				default: ctx_next.st = RSR_S_IDLE;
			endcase
		end
	end

	// one register holds the whole engine context
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) ctx_reg <= RSR_CTX_RESET;
		else ctx_reg <= ctx_next;
	end

	// checks on the engine context
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	property p_old_refresh_pointer_spec;
		(ctx_reg.st == RSR_S_IDLE && start && regs_in.old_refresh_pointer[2:0] != 3'h0)
			|=> (ctx_reg.st == RSR_S_DONE && ctx_reg.endc == RSR_END_SPEC);
	endproperty
	a_old_refresh_pointer_spec: assert property (p_old_refresh_pointer_spec) else $error("misaligned old refresh accepted");

	property p_new_refresh_pointer_spec;
		(ctx_reg.st == RSR_S_IDLE && start && regs_in.new_refresh_pointer[2:0] != 3'h0)
			|=> ##1 (done && end_code == RSR_END_SPEC);
	endproperty
	a_new_refresh_pointer_spec: assert property (p_new_refresh_pointer_spec) else $error("misaligned new refresh accepted");

	property p_old_table_pointer_step;
		(ctx_reg.st == RSR_S_TPROC) |=> (regs_out.old_table_pointer[23:0] ==
			$past(regs_out.old_table_pointer[23:0]) + 24'h000002);
	endproperty
	a_old_table_pointer_step: assert property (p_old_table_pointer_step) else $error("old table pointer step wrong");

	property p_refetch;
		(ctx_reg.st == RSR_S_TWR && ack_ok && !ctx_reg.held && !ctx_reg.tdone)
			|=> (ctx_reg.st == RSR_S_TRD && mem_req.valid && !mem_req.write
			&& mem_req.addr[2:0] == 3'h0);
	endproperty
	a_refetch: assert property (p_refetch) else $error("next table doubleword not fetched");

	property p_new_table_pointer_step;
		(ctx_reg.st == RSR_S_TWR && ack_ok) |=> (regs_out.new_table_pointer[23:0] ==
			$past(regs_out.new_table_pointer[23:0]) + 24'h000002);
	endproperty
	a_new_table_pointer_step: assert property (p_new_table_pointer_step) else $error("new table pointer step wrong");

	property p_bin_start;
		(ctx_reg.st == RSR_S_DISP && ack_ok) |=> (regs_out.sort_bin_fetch_pointer[23:0]
			== $past(ctx_reg.sort_bin_base_address) + $past(disp_word[23:0]));
	endproperty
	a_bin_start: assert property (p_bin_start) else $error("sort bin pointer start wrong");

	property p_bin_hold;
		(ctx_reg.st == RSR_S_TPROC || (ctx_reg.st == RSR_S_MOVE && !ctx_reg.insert_ph))
			|=> $stable(regs_out.sort_bin_fetch_pointer);
	endproperty
	a_bin_hold: assert property (p_bin_hold) else $error("sort bin pointer moved early");

	property p_sep_zero;
		(ctx_reg.st == RSR_S_TPROC && cur_desc[15:8] == 8'h00)
			|=> (mem_req.valid && mem_req.write && mem_req.wdata == 64'h0);
	endproperty
	a_sep_zero: assert property (p_sep_zero) else $error("separator not written as zero");

	property p_count_add;
		(ctx_reg.st == RSR_S_TPROC && cur_desc[15:8] != 8'h00)
			|=> (regs_out.history_symbol_count[15:0] + regs_out.current_symbol_count[15:0]
			== $past(regs_out.history_symbol_count[15:0] + regs_out.current_symbol_count[15:0])
			+ $past(desc_bytes));
	endproperty
	a_count_add: assert property (p_count_add) else $error("symbol byte count not added");

	sequence s_fault;
		ack && mem_rsp.err && busy;
	endsequence
	sequence s_stop;
		(ctx_reg.st == RSR_S_DONE && end_code == RSR_END_ADDR) ##1 (done && !busy);
	endsequence
	property p_fault_stop;
		s_fault |=> s_stop;
	endproperty
	a_fault_stop: assert property (p_fault_stop) else $error("fault did not end the run");

	property p_prefetch;
		(ctx_reg.st == RSR_S_MOVE && ctx_reg.pre && !mem_req.valid)
			|=> (mem_req.valid && !mem_req.write && mem_req.addr == $past(regs_out.old_refresh_pointer[23:0]));
	endproperty
	a_prefetch: assert property (p_prefetch) else $error("old refresh not prefetched");

	property p_table_first;
		(ctx_reg.st == RSR_S_TWR && ack_ok && ctx_reg.tdone && !irq_pending)
			|=> (ctx_reg.st == RSR_S_MOVE && !ctx_reg.insert_ph);
	endproperty
	a_table_first: assert property (p_table_first) else $error("image moving not after table");

endmodule : rsr_repacker

// [src/rsr_pkg.sv]
/*
 * Shared constants and types of the refresh symbol repacker: pointer steps,
 * alignment figures, re-entry codes, operand, memory request and context structs.
 * Assumes one 10 MHz processor clock and one doubleword storage port shared by
 * main storage and display refresh storage.
 */
// How it works
// - one run repacks radar and single-symbol data of one sort bin of one display.
// - sixteen sort bins per display; only the selected bin's table is used.
// - one internal pass per class/type, repeated until all class/types are done.
// - new descriptor table finished first, then old refresh becomes the new image.
// - a descriptor is a halfword: batch identifier byte, then symbol count byte.
// - all-zero descriptor separates history from current and class/type from class/type.
// - zero batch identifier counts as separator whatever its count; software never sends one.
// - low halves of the two count registers gather history and current bytes, unrestored.
// - old-table pointer addresses the next halfword descriptor, steps two per descriptor.
// - after the last held descriptor, fetch the next aligned doubleword at old-table pointer.
// - new-table pointer addresses the next halfword slot, steps two per descriptor written.
// - old-refresh pointer steps a doubleword per two symbols; misaligned start is refused.
// - old refresh is prefetched even when empty, so its pointer must stay valid.
// - new-refresh pointer steps a doubleword per two symbols; misaligned start is refused.
// - sort-bin fetch pointer starts as base address plus selected bin displacement.
// - sort-bin fetch pointer untouched until insertion, then a doubleword per two symbols.
// - after insertion the sort-bin pointer already points at the next data; not restored.
// - re-entry identifier zero starts afresh; nonzero resumes at the recorded point.
package rsr_pkg;

	localparam int unsigned RSR_ADDR_W     = 24;
	localparam int unsigned RSR_DW_W       = 64;
	localparam int unsigned RSR_FIFO_DEPTH = 16;

	localparam logic [23:0] RSR_DESC_STEP  = 24'h000002; // one halfword descriptor
	localparam logic [23:0] RSR_DW_STEP    = 24'h000008; // two symbols
	localparam logic [2:0]  RSR_DW_OFS0    = 3'h0;       // aligned doubleword offset
	localparam logic [1:0]  RSR_LAST_HALF  = 2'h3;       // last halfword of a doubleword
	localparam logic [7:0]  RSR_HALF_BE    = 8'hC0;      // byte enables of halfword 0
	localparam logic [3:0]  RSR_REENTRY_IMAGE = 4'h9;    // resume at refresh image moving
	localparam logic [7:0]  RSR_EXIT_TABLE = 8'h91;      // exit after descriptor work
	localparam logic [7:0]  RSR_REENTRY_NONE = 8'h00;
	localparam logic [16:0] RSR_DW_ROUND   = 17'h00007;  // bytes rounded up to doublewords
	localparam logic [16:0] RSR_SYM_ROUND  = 17'h00001;  // symbols rounded up to pairs

	typedef struct packed {
		logic [31:0] history_symbol_count;
		logic [31:0] current_symbol_count;
		logic [31:0] old_table_pointer;
		logic [31:0] new_table_pointer;
		logic [31:0] old_refresh_pointer;
		logic [31:0] new_refresh_pointer;
		logic [31:0] sort_bin_fetch_pointer;
	} rsr_regs_s;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [23:0] addr;
		logic [63:0] wdata;
		logic [7:0]  be;
	} rsr_mem_req_s;

	typedef struct packed {
		logic        ack;
		logic        err;
		logic [63:0] rdata;
	} rsr_mem_rsp_s;

	typedef enum logic [3:0] {
		RSR_S_IDLE  = 4'h0,
		RSR_S_DISP  = 4'h1,
		RSR_S_TRD   = 4'h2,
		RSR_S_TPROC = 4'h3,
		RSR_S_TWR   = 4'h4,
		RSR_S_MOVE  = 4'h5,
		RSR_S_DONE  = 4'h6
	} rsr_state_e;

	typedef enum logic [1:0] {
		RSR_END_OK   = 2'h0,
		RSR_END_SPEC = 2'h1,
		RSR_END_ADDR = 2'h2,
		RSR_END_INTR = 2'h3
	} rsr_end_e;

	typedef struct packed {
		rsr_state_e   st;
		rsr_regs_s    regs;
		rsr_mem_req_s req;
		logic [63:0]  dw;
		logic         held;
		logic [3:0]   classes_left;
		logic         in_current;
		logic         tdone;
		logic         insert_ph;
		logic         pre;
		logic [15:0]  rd_left;
		logic [15:0]  wr_left;
		logic [7:0]   reent;
		rsr_end_e     endc;
		logic         done;
		logic         busy;
		logic [23:0]  sort_bin_base_address;
		logic [23:0]  work_control_table;
		logic [3:0]   bin;
		logic [15:0]  nsym;
		logic         radar;
	} rsr_ctx_s;

	localparam rsr_ctx_s RSR_CTX_RESET = '0;

endpackage : rsr_pkg

// [verification/rsr_mem_model.sv]
/* storage model: doubleword store for the repacker port, answering with ack/err.
 * assumes one request outstanding; addresses with top nibble F fault. */
`timescale 1ns/1ns
module rsr_mem_model
	import rsr_pkg::*;
(
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	input  wire rsr_mem_req_s mem_req,
	output rsr_mem_rsp_s      mem_rsp
);
	logic [63:0] mem [logic [20:0]];
	int          n_req = 0;
	int          wait_n = 0;
	logic [20:0] a;
	logic        bad;
	assign a = mem_req.addr[23:3];
	assign bad = (mem_req.addr[23:20] == 4'hF);
	// answer after 0..3 cycles; read data keeps toggling while nothing is answered
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mem_rsp <= '0;
			wait_n <= 0;
		end else if (mem_req.valid && !mem_rsp.ack && wait_n >= n_req % 4) begin
			mem_rsp.ack <= 1'b1;
			mem_rsp.err <= bad;
			mem_rsp.rdata <= mem.exists(a) ? mem[a] : {43'h0, a};
			if (mem_req.write && !bad) begin
				if (!mem.exists(a)) mem[a] = '0;
				for (int k = 0; k < 8; k++)
					if (mem_req.be[k]) mem[a][8*k +: 8] = mem_req.wdata[8*k +: 8];
			end
			n_req <= n_req + 1;
			wait_n <= 0;
		end else begin
			mem_rsp.ack <= 1'b0;
			mem_rsp.rdata <= ~mem_rsp.rdata;
			wait_n <= mem_req.valid ? wait_n + 1 : 0;
		end
	end
endmodule : rsr_mem_model

// [verification/rsr_repacker_bench.sv]
/* self-checking bench of the refresh symbol repacker with its storage model.
 * assumes the model faults top-nibble-F addresses and answers all others. */
`timescale 1ns/1ns
module rsr_repacker_bench;
	import rsr_pkg::*;
	localparam logic [23:0] OLD_DESCRIPTOR_TABLE = 24'h002000, NEW_DESCRIPTOR_TABLE = 24'h003000, ORM = 24'h004000;
	localparam logic [23:0] NRM = 24'h005000, WORK_CONTROL_TABLE = 24'h001000;
	logic         clk_sys = 0, rstn = 0, start = 0, irq_pending = 0;
	rsr_regs_s    regs_in = '0, regs_out;
	logic [23:0]  sort_bin_base_address_in = 24'h000208;
	logic [3:0]   bin_sel = 4'h0;
	logic [3:0]   class_count = 4'h2;
	logic         class_radar = 1'b1;
	logic [15:0]  new_sym_count = 16'h0000;
	logic [7:0]   reentry_in = 8'h00, reentry_out;
	rsr_mem_req_s mem_req;
	rsr_mem_rsp_s mem_rsp;
	rsr_end_e     end_code;
	logic         busy, done;
	int           n_errors = 0, samples_checked = 0, cyc = 0;
	rsr_repacker u_rsr_repacker (.clk_sys(clk_sys), .rstn(rstn), .start(start),
		.regs_in(regs_in), .sort_bin_base_address_in(sort_bin_base_address_in), .bin_sel(bin_sel), .wct_addr(WORK_CONTROL_TABLE),
		.class_count(class_count), .class_radar(class_radar), .new_sym_count(new_sym_count),
		.reentry_in(reentry_in), .irq_pending(irq_pending), .mem_rsp(mem_rsp),
		.mem_req(mem_req), .regs_out(regs_out), .reentry_out(reentry_out),
		.end_code(end_code), .busy(busy), .done(done));
	rsr_mem_model u_rsr_mem_model (.clk_sys(clk_sys), .rstn(rstn), .mem_req(mem_req),
		.mem_rsp(mem_rsp));
	always #50 clk_sys = ~clk_sys;
	// cut a hang short
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			conclude();
		end
	end
	function automatic logic [23:0] disp(input logic [3:0] b);
		return 24'h000100 + {14'h0, b, 6'h0};
	endfunction : disp
	function automatic logic [63:0] m(input logic [23:0] ad);
		return u_rsr_mem_model.mem.exists(ad[23:3]) ? u_rsr_mem_model.mem[ad[23:3]] : 'x;
	endfunction : m
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// fresh storage image and operands, driven at a rising edge
	task automatic setup(input logic [7:0] c [4], input logic [15:0] ns,
		input logic [23:0] o, r, input logic [15:0] h);
		logic [3:0] b;
		b = 4'($urandom);
		u_rsr_mem_model.mem.delete();
		for (int j = 0; j < 8; j++)
			u_rsr_mem_model.mem[WORK_CONTROL_TABLE[23:3] + j] = {8'h0, disp(4'(2*j)), 8'h0, disp(4'(2*j+1))};
		u_rsr_mem_model.mem[OLD_DESCRIPTOR_TABLE[23:3]] = {8'h11, c[0], 16'h0, 8'h12, c[1], 16'h0};
		u_rsr_mem_model.mem[OLD_DESCRIPTOR_TABLE[23:3] + 1] = {8'h21, c[2], 16'h0, 8'h22, c[3], 16'h0};
		for (int j = 0; j < 48; j++) begin
			u_rsr_mem_model.mem[ORM[23:3] + j] = {$urandom, $urandom};
			u_rsr_mem_model.mem[(sort_bin_base_address_in + disp(b)) / 8 + j] = {$urandom, $urandom};
		end
		@(posedge clk_sys);
		regs_in <= '{{16'h0, h}, {16'h0, h}, {8'h0, OLD_DESCRIPTOR_TABLE}, {8'h0, NEW_DESCRIPTOR_TABLE},
			{8'h0, o}, {8'h0, r}, 32'h0};
		new_sym_count <= ns;
		bin_sel <= b;
	endtask : setup
	task automatic run(input logic [7:0] re, input logic irq);
		@(posedge clk_sys);
		reentry_in <= re;
		irq_pending <= irq;
		start <= 1'b1;
		@(posedge clk_sys);
		start <= 1'b0;
		#1 check("busy", busy, 1'b1);
		for (int k = 0; k < 3000 && done !== 1'b1; k++) begin
			@(posedge clk_sys);
			#1;
		end
		check("done", done, 1'b1);
		check("idle", busy, 1'b0);
	endtask : run
	task automatic check_ok(input logic [7:0] c [4], input logic [15:0] ns, input logic [15:0] k);
		int nd, ni;
		logic [23:0] sb;
		nd = (2 * k + 4 * (c[0] + c[1] + c[2] + c[3]) + 7) / 8;
		ni = (ns + 1) / 2;
		sb = sort_bin_base_address_in + disp(bin_sel);
		check("end", end_code, RSR_END_OK);
		check("hct", regs_out.history_symbol_count[15:0],
			k + (class_radar ? 4 * (c[0] + c[2]) : 0));
		check("cct", regs_out.current_symbol_count[15:0],
			k + 4 * (c[1] + c[3] + (class_radar ? 0 : c[0] + c[2])));
		check("otp", regs_out.old_table_pointer, OLD_DESCRIPTOR_TABLE + 16);
		check("ntp", regs_out.new_table_pointer, NEW_DESCRIPTOR_TABLE + 16);
		check("orp", regs_out.old_refresh_pointer, ORM + 8 * nd);
		check("nrp", regs_out.new_refresh_pointer, NRM + 8 * (nd + ni));
		check("sbp", regs_out.sort_bin_fetch_pointer, sb + 8 * ni);
		check("rid", reentry_out, RSR_REENTRY_NONE);
		for (int j = 0; j < 16; j += 8)
			check("ndt", m(NEW_DESCRIPTOR_TABLE + j), m(OLD_DESCRIPTOR_TABLE + j));
		for (int j = 0; j < nd + ni; j++)
			check("img", m(NRM + 8 * j), j < nd ? m(ORM + 8 * j) : m(sb + 8 * (j - nd)));
	endtask : check_ok
	task automatic conclude();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	// empty bin, full bin filling the buffer, interrupt and resume, kept counts,
	// single-symbol classes, random bins, faults
	initial begin
		logic [7:0] c [4];
		logic [15:0] ns;
		logic [23:0] o;
		int n;
		void'($urandom(7986));
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		for (int t = 0; t < 6; t++) begin
			foreach (c[i]) c[i] = (t == 0) ? 8'h00 : (t == 1) ? 8'd20 : 8'($urandom_range(20));
			ns = (t == 0) ? 16'h0 : (t == 1) ? 16'h9 : 16'($urandom_range(9));
			setup(c, ns, ORM, NRM, (t == 3) ? 16'h0008 : 16'($urandom));
			class_radar <= (t != 4);
			class_count <= (t != 4) ? 4'h2 : 4'h4;
			if (t == 2) begin
				run(RSR_REENTRY_NONE, 1'b1);
				check("irq", end_code, RSR_END_INTR);
				check("xid", reentry_out, RSR_EXIT_TABLE);
				@(posedge clk_sys);
				regs_in <= regs_out;
				run(RSR_EXIT_TABLE, 1'b0);
			end else
				run((t == 3) ? 8'h01 : RSR_REENTRY_NONE, 1'b0);
			check_ok(c, ns, (t == 3) ? 16'h0008 : 16'h0000);
		end
		for (int t = 0; t < 3; t++) begin
			n = u_rsr_mem_model.n_req;
			o = (t == 0) ? ORM + 4 : (t == 1) ? 24'hF00000 : ORM;
			setup(c, ns, o, (t == 2) ? NRM + 4 : NRM, 16'h0000);
			run(RSR_REENTRY_NONE, 1'b0);
			check("flt", end_code, (t == 1) ? RSR_END_ADDR : RSR_END_SPEC);
			check("orf", regs_out.old_refresh_pointer, o);
			if (t != 1) check("acc", u_rsr_mem_model.n_req - n, 0);
		end
		conclude();
	end
endmodule : rsr_repacker_bench
